//--- common/mbc_params.svh
// Constants for the branch, control, move and flag execution core.
// Assumes inclusion by bare name from the design file.
`ifndef MBC_PARAMS_SVH
`define MBC_PARAMS_SVH
`define MBC_OFF_CTRL 8'h00
`define MBC_OFF_STATUS 8'h04
`define MBC_OFF_ACC 8'h08
`define MBC_OFF_PSW 8'h0C
`define MBC_OFF_PC 8'h10
`define MBC_PSW_RESET 8'h08
`define MBC_PSW_CARRY 7
`define MBC_PSW_FLAG0 5
`define MBC_PSW_BANK 4
`define MBC_RB_HIGH_BASE 3'b011
`define MBC_PAGE_THREE 3'b011
`define MBC_OP_JNTZ 8'h26
`define MBC_OP_BRANCH_TEST_ZERO_LOW 8'h46
`define MBC_OP_JTZ 8'h36
`define MBC_OP_JTO 8'h56
`define MBC_OP_JNZ 8'h96
`define MBC_OP_JZ 8'hC6
`define MBC_OP_JTF 8'h16
`define MBC_OP_CALL 8'b???1_0100
`define MBC_OP_IRQ_EN 8'h05
`define MBC_OP_IRQ_DIS 8'h15
`define MBC_OP_CLK_OUT 8'h75
`define MBC_OP_PB_LOW 8'hE5
`define MBC_OP_PB_HIGH 8'hF5
`define MBC_OP_RB_LOW 8'hC5
`define MBC_OP_RB_HIGH 8'hD5
`define MBC_OP_MOV_A_IMM 8'h23
`define MBC_OP_MOV_A_R 8'b1111_1???
`define MBC_OP_MOV_A_IND 8'b1111_000?
`define MBC_OP_MOV_A_PSW 8'hC7
`define MBC_OP_MOV_R_IMM 8'b1011_1???
`define MBC_OP_MOV_R_A 8'b1010_1???
`define MBC_OP_MOV_IND_A 8'b1010_000?
`define MBC_OP_MOV_IND_IMM 8'b1011_000?
`define MBC_OP_MOV_PSW_A 8'hD7
`define MBC_OP_PAGE_TABLE_READ 8'hA3
`define MBC_OP_PAGE_THREE_TABLE_READ 8'hE3
`define MBC_OP_EXTERNAL_DATA_MOVE_RD 8'b1000_000?
`define MBC_OP_EXTERNAL_DATA_MOVE_WR 8'b1001_000?
`define MBC_OP_XCH_R 8'b0010_1???
`define MBC_OP_XCH_IND 8'b0010_000?
`define MBC_OP_SWAP_LOW_NIBBLE 8'b0011_000?
`define MBC_OP_CPL_C 8'hA7
`define MBC_OP_CPL_F0 8'h95
`define MBC_OP_CPL_F1 8'hB5
`define MBC_OP_CLR_C 8'h97
`define MBC_OP_CLR_F0 8'h85
`define MBC_OP_CLR_F1 8'hA5
`endif

//--- common/mbc_pkg.sv
// Types shared by the execution core and its bench.
// Assumes mbc_params.svh on the include path.
package mbc_pkg;
  typedef enum logic [2:0] {
    S_IDLE = 3'b000,
    S_FETCH = 3'b001,
    S_DECODE = 3'b011,
    S_OPA = 3'b010,
    S_OPD = 3'b110
  } mbc_state_t;
  typedef struct packed {
    logic [11:0] addr;
    logic rd;
  } mbc_pbus_t;
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic rd;
    logic wr;
  } mbc_xbus_t;
endpackage : mbc_pkg

//--- rtl/mbc_core.sv
// Execution core for branches, control, moves and flag operations of an 8-bit controller.
// Assumes program and external data memories answer combinationally within the strobe cycle.
//
// Function
// RULE_01: Jump on test zero low loads PC low byte, else skips two bytes.
// RULE_02: Jump on test one low loads PC low byte, else skips two bytes.
// RULE_03: Jump on test zero high loads PC low byte, else skips two bytes.
// RULE_04: Jump on accumulator nonzero loads PC low byte, two bytes, two cycles.
// RULE_05: Jump on accumulator zero loads PC low byte, else skips both bytes.
// RULE_06: Jump on timer overflow flag branches in page, else skips two bytes.
// RULE_07: One-cycle instruction enables external interrupt recognition.
// RULE_08: One-cycle instruction disables external interrupt recognition; pin then ignored.
// RULE_09: One-cycle instruction turns test zero pin into state clock output.
// RULE_10: Clear or set program bank flag selects low or high 2K bank.
// RULE_11: Clear or set register bank maps working registers to 0-7 or 24-31.
// RULE_12: Indirect load reads data memory addressed by register 0 or 1.
// RULE_13: One-cycle moves of status word to and from accumulator.
// RULE_14: Current-page table read addresses by accumulator, loads byte, two cycles.
// RULE_15: Page-three table read forces address bits 8-10 to 011.
// RULE_16: External read uses register 0 or 1 as address, loads accumulator.
// RULE_17: External write puts register address then accumulator on bus, two cycles.
// RULE_18: Immediate register load writes second byte into selected working register.
// RULE_19: Register swap exchanges accumulator and selected working register in one cycle.
// RULE_20: Nibble swap exchanges low nibbles only with indirect data byte.
// RULE_21: Complement carry, flag zero or flag one, touching only that flag.
// RULE_22: Clear carry, flag zero or flag one, touching only that flag.
// RULE_23: Subroutine call copies program bank flag into PC bit 11.
// RULE_24: Test zero pin is an input unless switched to clock output.
// RULE_25: Jump conditions are sampled during the jump instruction itself.
//
// The address map and the APB register port were chosen for this implementation.
`timescale 1ns/100ps
`include "mbc_params.svh"
module mbc_core (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output mbc_pkg::mbc_pbus_t prog,
  input wire logic [7:0] prog_data,
  output mbc_pkg::mbc_xbus_t xbus,
  input wire logic [7:0] xd_rdata,
  input wire logic test_input_zero,
  output logic t0_out,
  output logic t0_oe,
  input wire logic test_input_one,
  input wire logic timer_overflow_flag,
  input wire logic ext_irq_n,
  output logic ext_irq_seen,
  output logic pc_bank_bit
);

  // ********************************
  // State and storage
  // ********************************
  mbc_pkg::mbc_state_t state;
  mbc_pkg::mbc_state_t next_state;
  logic [7:0] dram [0:127];
  logic [7:0] acc;
  logic [7:0] program_status_word;
  logic [7:0] ir;
  logic [11:0] pc;
  logic user_flag_one;
  logic irq_en;
  logic clk_out_en;
  logic program_bank_flag;
  logic run;
  logic cond;
  logic [7:0] op_now;
  logic [6:0] reg_ptr;
  logic [6:0] ind_ptr;
  logic [7:0] reg_val;
  logic [7:0] ind_val;
  logic test_zero_eff;
  logic ram_we;
  logic [6:0] ram_wa;
  logic [7:0] ram_wd;
  logic apb_wr;
  logic sw_ok;

  // ********************************
  // Decode helpers
  // ********************************
  function automatic logic [6:0] reg_addr(input logic bank, input logic [2:0] r);
    reg_addr = bank ? {1'b0, `MBC_RB_HIGH_BASE, r} : {4'h0, r};
  endfunction : reg_addr

  function automatic logic is_branch(input logic [7:0] op);
    case (op)
      `MBC_OP_JNTZ, `MBC_OP_BRANCH_TEST_ZERO_LOW, `MBC_OP_JTZ, `MBC_OP_JTO,
      `MBC_OP_JNZ, `MBC_OP_JZ, `MBC_OP_JTF: is_branch = 1'b1;
      default: is_branch = 1'b0;
    endcase
  endfunction : is_branch

  function automatic logic two_cycle(input logic [7:0] op);
    casez (op)
      `MBC_OP_CALL, `MBC_OP_MOV_A_IMM, `MBC_OP_MOV_R_IMM, `MBC_OP_MOV_IND_IMM,
      `MBC_OP_PAGE_TABLE_READ, `MBC_OP_PAGE_THREE_TABLE_READ, `MBC_OP_EXTERNAL_DATA_MOVE_RD, `MBC_OP_EXTERNAL_DATA_MOVE_WR: two_cycle = 1'b1;
      default: two_cycle = is_branch(op);
    endcase
  endfunction : two_cycle

  function automatic logic branch_cond(input logic [7:0] op, input logic tz, input logic to,
                                       input logic tf, input logic [7:0] a);
    case (op)
      `MBC_OP_JNTZ: branch_cond = ~tz;
      `MBC_OP_BRANCH_TEST_ZERO_LOW: branch_cond = ~to;
      `MBC_OP_JTZ: branch_cond = tz;
      `MBC_OP_JTO: branch_cond = to;
      `MBC_OP_JNZ: branch_cond = (a != 8'h00);
      `MBC_OP_JZ: branch_cond = (a == 8'h00);
      `MBC_OP_JTF: branch_cond = tf;
      default: branch_cond = 1'b0;
    endcase
  endfunction : branch_cond

  function automatic logic apb_mapped(input logic [31:0] a);
    apb_mapped = (a == {24'h0, `MBC_OFF_CTRL}) || (a == {24'h0, `MBC_OFF_STATUS}) ||
                 (a == {24'h0, `MBC_OFF_ACC}) || (a == {24'h0, `MBC_OFF_PSW}) ||
                 (a == {24'h0, `MBC_OFF_PC});
  endfunction : apb_mapped

  // The opcode in DECODE arrives on prog_data; later phases use the latched copy.
  assign op_now = (state == mbc_pkg::S_DECODE) ? prog_data : ir;
  assign reg_ptr = reg_addr(program_status_word[`MBC_PSW_BANK], op_now[2:0]);
  assign ind_ptr = dram[reg_addr(program_status_word[`MBC_PSW_BANK], {2'b00, op_now[0]})][6:0];
  assign reg_val = dram[reg_ptr];
  assign ind_val = dram[ind_ptr];
  // RULE_24 pin as input
  assign test_zero_eff = clk_out_en ? t0_out : test_input_zero;
  assign apb_wr = psel && penable && pready && pwrite;
  // Software may only load core state while the core is stopped.
  assign sw_ok = apb_wr && !run && (state == mbc_pkg::S_IDLE);

  // ********************************
  // Sequencer
  // ********************************
  always_comb begin
    next_state = state;
    case (state)
      mbc_pkg::S_IDLE: next_state = run ? mbc_pkg::S_FETCH : mbc_pkg::S_IDLE;
      mbc_pkg::S_FETCH: next_state = mbc_pkg::S_DECODE;
      mbc_pkg::S_DECODE: begin
        if (two_cycle(prog_data)) begin
          next_state = mbc_pkg::S_OPA;
        end else begin
          next_state = run ? mbc_pkg::S_FETCH : mbc_pkg::S_IDLE;
        end
      end
      mbc_pkg::S_OPA: next_state = mbc_pkg::S_OPD;
      mbc_pkg::S_OPD: next_state = run ? mbc_pkg::S_FETCH : mbc_pkg::S_IDLE;
      default: next_state = mbc_pkg::S_IDLE;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= mbc_pkg::S_IDLE;
      ir <= 8'h00;
      cond <= 1'b0;
    end else begin
      state <= next_state;
      if (state == mbc_pkg::S_DECODE) begin
        ir <= prog_data;
        // RULE_25 sample condition
        cond <= branch_cond(prog_data, test_zero_eff, test_input_one,
                            timer_overflow_flag, acc);
      end
    end
  end

  // ********************************
  // Program counter and program bus
  // ********************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pc <= 12'h000;
    end else if (state == mbc_pkg::S_DECODE) begin
      pc <= pc + 12'h001;
    end else if (state == mbc_pkg::S_OPA) begin
      // Operand byte fetch advances past the second byte.
      if (is_branch(ir) || ir == `MBC_OP_MOV_A_IMM || ir[7:3] == 5'b10111 ||
          ir[7:1] == 7'b1011000 || ir[4:0] == 5'b10100) begin
        pc <= pc + 12'h001;
      end
    end else if (state == mbc_pkg::S_OPD) begin
      // RULE_01 RULE_02 RULE_03 branch load
      // RULE_04 RULE_05 RULE_06 in-page branch
      if (is_branch(ir) && cond) begin
        pc <= {pc[11:8], prog_data};
      end else if (ir[4:0] == 5'b10100) begin
        // RULE_23 bank into bit 11
        pc <= {program_bank_flag, ir[7:5], prog_data};
      end
    end else if (sw_ok && paddr[7:0] == `MBC_OFF_PC) begin
      pc <= pwdata[11:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prog <= '0;
    end else if (state == mbc_pkg::S_FETCH) begin
      prog.addr <= pc;
      prog.rd <= 1'b1;
    end else if (state == mbc_pkg::S_OPA && two_cycle(ir) && ir[7:1] != 7'b1000000 &&
                 ir[7:1] != 7'b1001000) begin
      prog.rd <= 1'b1;
      if (ir == `MBC_OP_PAGE_TABLE_READ) begin
        // RULE_14 current page table
        prog.addr <= {pc[11:8], acc};
      end else if (ir == `MBC_OP_PAGE_THREE_TABLE_READ) begin
        // RULE_15 page three
        prog.addr <= {pc[11], `MBC_PAGE_THREE, acc};
      end else begin
        prog.addr <= pc;
      end
    end else begin
      prog.rd <= 1'b0;
    end
  end

  // ********************************
  // External data bus
  // ********************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      xbus <= '0;
    end else if (state == mbc_pkg::S_OPA && (ir[7:1] == 7'b1000000 || ir[7:1] == 7'b1001000)) begin
      // RULE_16 RULE_17 address from R0 or R1
      xbus.addr <= dram[reg_addr(program_status_word[`MBC_PSW_BANK], {2'b00, ir[0]})];
      xbus.wdata <= acc;
      xbus.rd <= ~ir[4];
      xbus.wr <= ir[4];
    end else begin
      xbus.rd <= 1'b0;
      xbus.wr <= 1'b0;
    end
  end

  // ********************************
  // Accumulator
  // ********************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      acc <= 8'h00;
    end else if (state == mbc_pkg::S_DECODE) begin
      casez (prog_data)
        `MBC_OP_MOV_A_R: acc <= reg_val;
        // RULE_12 indirect load
        `MBC_OP_MOV_A_IND: acc <= ind_val;
        // RULE_13 status to accumulator
        `MBC_OP_MOV_A_PSW: acc <= program_status_word;
        // RULE_19 register swap
        `MBC_OP_XCH_R: acc <= reg_val;
        `MBC_OP_XCH_IND: acc <= ind_val;
        // RULE_20 low nibble swap
        `MBC_OP_SWAP_LOW_NIBBLE: acc <= {acc[7:4], ind_val[3:0]};
        default: acc <= acc;
      endcase
    end else if (state == mbc_pkg::S_OPD) begin
      casez (ir)
        `MBC_OP_MOV_A_IMM: acc <= prog_data;
        // RULE_14 RULE_15 table byte
        `MBC_OP_PAGE_TABLE_READ, `MBC_OP_PAGE_THREE_TABLE_READ: acc <= prog_data;
        // RULE_16 external read
        `MBC_OP_EXTERNAL_DATA_MOVE_RD: acc <= xd_rdata;
        default: acc <= acc;
      endcase
    end else if (sw_ok && paddr[7:0] == `MBC_OFF_ACC) begin
      acc <= pwdata[7:0];
    end
  end

  // ********************************
  // Internal data memory
  // ********************************
  always_comb begin
    ram_we = 1'b0;
    ram_wa = reg_ptr;
    ram_wd = acc;
    if (state == mbc_pkg::S_DECODE) begin
      casez (prog_data)
        `MBC_OP_MOV_R_A, `MBC_OP_XCH_R: ram_we = 1'b1;
        `MBC_OP_MOV_IND_A, `MBC_OP_XCH_IND: begin
          ram_we = 1'b1;
          ram_wa = ind_ptr;
        end
        `MBC_OP_SWAP_LOW_NIBBLE: begin
          ram_we = 1'b1;
          ram_wa = ind_ptr;
          ram_wd = {ind_val[7:4], acc[3:0]};
        end
        default: ram_we = 1'b0;
      endcase
    end else if (state == mbc_pkg::S_OPD) begin
      casez (ir)
        // RULE_18 immediate register load
        `MBC_OP_MOV_R_IMM: begin
          ram_we = 1'b1;
          ram_wd = prog_data;
        end
        `MBC_OP_MOV_IND_IMM: begin
          ram_we = 1'b1;
          ram_wa = ind_ptr;
          ram_wd = prog_data;
        end
        default: ram_we = 1'b0;
      endcase
    end
  end

  always_ff @(posedge pclk) begin
    if (ram_we) begin
      dram[ram_wa] <= ram_wd;
    end
  end

  // ********************************
  // Status word and flags
  // ********************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      program_status_word <= `MBC_PSW_RESET;
      user_flag_one <= 1'b0;
    end else if (state == mbc_pkg::S_DECODE) begin
      case (prog_data)
        // RULE_13 accumulator to status
        `MBC_OP_MOV_PSW_A: program_status_word <= acc;
        // RULE_21 complement flags
        `MBC_OP_CPL_C: program_status_word[`MBC_PSW_CARRY] <= ~program_status_word[`MBC_PSW_CARRY];
        `MBC_OP_CPL_F0: program_status_word[`MBC_PSW_FLAG0] <= ~program_status_word[`MBC_PSW_FLAG0];
        `MBC_OP_CPL_F1: user_flag_one <= ~user_flag_one;
        // RULE_22 clear flags
        `MBC_OP_CLR_C: program_status_word[`MBC_PSW_CARRY] <= 1'b0;
        `MBC_OP_CLR_F0: program_status_word[`MBC_PSW_FLAG0] <= 1'b0;
        `MBC_OP_CLR_F1: user_flag_one <= 1'b0;
        // RULE_11 register bank select
        `MBC_OP_RB_LOW: program_status_word[`MBC_PSW_BANK] <= 1'b0;
        `MBC_OP_RB_HIGH: program_status_word[`MBC_PSW_BANK] <= 1'b1;
        default: program_status_word <= program_status_word;
      endcase
    end else if (sw_ok && paddr[7:0] == `MBC_OFF_PSW) begin
      program_status_word <= pwdata[7:0];
    end
  end

  // ********************************
  // Control flip-flops and pins
  // ********************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_en <= 1'b0;
      clk_out_en <= 1'b0;
      program_bank_flag <= 1'b0;
    end else if (state == mbc_pkg::S_DECODE) begin
      case (prog_data)
        // RULE_07 RULE_08 interrupt gate
        `MBC_OP_IRQ_EN: irq_en <= 1'b1;
        `MBC_OP_IRQ_DIS: irq_en <= 1'b0;
        // RULE_09 clock output
        `MBC_OP_CLK_OUT: clk_out_en <= 1'b1;
        // RULE_10 program bank
        `MBC_OP_PB_LOW: program_bank_flag <= 1'b0;
        `MBC_OP_PB_HIGH: program_bank_flag <= 1'b1;
        default: irq_en <= irq_en;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      t0_out <= 1'b0;
      t0_oe <= 1'b0;
      ext_irq_seen <= 1'b0;
      pc_bank_bit <= 1'b0;
    end else begin
      // RULE_09 state clock is pclk halved
      t0_out <= clk_out_en & ~t0_out;
      t0_oe <= clk_out_en;
      // RULE_08 pin ignored while disabled
      ext_irq_seen <= irq_en & ~ext_irq_n;
      pc_bank_bit <= pc[11];
    end
  end

  // ********************************
  // APB slave
  // ********************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      run <= 1'b0;
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end else begin
      pready <= psel & ~penable;
      pslverr <= psel & ~penable & ~apb_mapped(paddr);
      if (apb_wr && paddr[7:0] == `MBC_OFF_CTRL && paddr[31:8] == 24'h0) begin
        run <= pwdata[0];
      end
      if (psel && !penable) begin
        case (paddr[7:0])
          `MBC_OFF_CTRL: prdata <= {31'h0, run};
          `MBC_OFF_STATUS: prdata <= {26'h0, state != mbc_pkg::S_IDLE, user_flag_one,
                                      clk_out_en, irq_en, program_status_word[`MBC_PSW_BANK], program_bank_flag};
          `MBC_OFF_ACC: prdata <= {24'h0, acc};
          `MBC_OFF_PSW: prdata <= {24'h0, program_status_word};
          `MBC_OFF_PC: prdata <= {20'h0, pc};
          default: prdata <= 32'h0000_0000;
        endcase
        if (!apb_mapped(paddr)) begin
          prdata <= 32'h0000_0000;
        end
      end
    end
  end

  // ********************************
  // Assertions
  // ********************************
  branch_skip_a: assert property (@(posedge pclk) disable iff (!presetn) // RULE_01
    state == mbc_pkg::S_OPD && is_branch(ir) && !cond |=> pc == $past(pc))
    else $error("untaken jump changed the counter");
  branch_load_a: assert property (@(posedge pclk) disable iff (!presetn) // RULE_04
    state == mbc_pkg::S_OPD && is_branch(ir) && cond |=> pc[7:0] == $past(prog_data))
    else $error("taken jump did not load the operand");
  acc_zero_cond_a: assert property (@(posedge pclk) disable iff (!presetn) // RULE_05
    state == mbc_pkg::S_DECODE && prog_data == `MBC_OP_JZ && acc == 8'h00 |=> cond)
    else $error("zero test missed");
  irq_gate_a: assert property (@(posedge pclk) disable iff (!presetn) // RULE_08
    state == mbc_pkg::S_DECODE && prog_data == `MBC_OP_IRQ_DIS |=> ##1 !ext_irq_seen)
    else $error("interrupt seen after disable");
  irq_open_a: assert property (@(posedge pclk) disable iff (!presetn) // RULE_07
    state == mbc_pkg::S_DECODE && prog_data == `MBC_OP_IRQ_EN && !ext_irq_n ##1 !ext_irq_n
    |=> ext_irq_seen)
    else $error("interrupt not seen after enable");
  clock_out_a: assert property (@(posedge pclk) disable iff (!presetn) // RULE_09
    state == mbc_pkg::S_DECODE && prog_data == `MBC_OP_CLK_OUT |=> ##1 t0_oe)
    else $error("test zero pin not driven");
  page_three_a: assert property (@(posedge pclk) disable iff (!presetn) // RULE_15
    state == mbc_pkg::S_OPA && ir == `MBC_OP_PAGE_THREE_TABLE_READ |=> prog.rd && prog.addr[10:8] == 3'b011)
    else $error("page three address wrong");
  ext_write_a: assert property (@(posedge pclk) disable iff (!presetn) // RULE_17
    state == mbc_pkg::S_OPA && ir[7:1] == 7'b1001000 |=> xbus.wr && xbus.wdata == $past(acc)
    ##1 !xbus.wr)
    else $error("external write strobe wrong");
  carry_cpl_a: assert property (@(posedge pclk) disable iff (!presetn) // RULE_21
    state == mbc_pkg::S_DECODE && prog_data == `MBC_OP_CPL_C
    |=> program_status_word[7] != $past(program_status_word[7]) && program_status_word[6:0] == $past(program_status_word[6:0]))
    else $error("carry complement wrong");
  flag_clr_a: assert property (@(posedge pclk) disable iff (!presetn) // RULE_22
    state == mbc_pkg::S_DECODE && prog_data == `MBC_OP_CLR_F0
    |=> !program_status_word[5] && program_status_word[7] == $past(program_status_word[7]) && user_flag_one == $past(user_flag_one))
    else $error("flag zero clear wrong");
  reg_bank_a: assert property (@(posedge pclk) disable iff (!presetn) // RULE_11
    state == mbc_pkg::S_DECODE && prog_data == `MBC_OP_RB_HIGH |=> program_status_word[4])
    else $error("register bank not set");
  cover_taken_c: cover property (@(posedge pclk) state == mbc_pkg::S_OPD && is_branch(ir) && cond);
  cover_xread_c: cover property (@(posedge pclk) xbus.rd);
  cover_swap_low_nibble_c: cover property (@(posedge pclk)
    state == mbc_pkg::S_DECODE && prog_data[7:1] == 7'b0011000);

endmodule : mbc_core

//--- sim/mbc_mem_model.sv
// Program and external data memory seen from the far side of the execution core.
// Assumes the core strobes prog.rd and xbus.rd/wr for one pclk cycle each.
`timescale 1ns/100ps
module mbc_mem_model (
  input wire logic pclk,
  input wire mbc_pkg::mbc_pbus_t prog,
  output logic [7:0] prog_data,
  input wire mbc_pkg::mbc_xbus_t xbus,
  output logic [7:0] xd_rdata
);
  logic [7:0] pmem [0:4095];
  logic [7:0] xmem [0:255];
  initial begin
    for (int i = 0; i < 4096; i++) begin
      pmem[i] = 8'h00;
    end
    for (int i = 0; i < 256; i++) begin
      xmem[i] = 8'h00;
    end
  end
  // Outside a strobe the lines show the inverse, so a late sample is caught.
  assign prog_data = prog.rd ? pmem[prog.addr] : ~pmem[prog.addr];
  assign xd_rdata = xbus.rd ? xmem[xbus.addr] : ~xmem[xbus.addr];
  always_ff @(posedge pclk) begin
    if (xbus.wr) begin
      xmem[xbus.addr] <= xbus.wdata;
    end
  end
endmodule : mbc_mem_model

//--- sim/testbench.sv
// Self-checking bench: runs a short program through the core and reads its state over APB.
// Assumes mbc_mem_model as the memories and the zero-wait APB answer of the core.
`timescale 1ns/100ps
`define CHK(nm, e, g) begin num_checks++; if ((g) !== (e)) begin n_mismatch++; \
  $display("mismatch %s expected %h seen %h", nm, e, g); end end
module testbench;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, t0_drv, t0_out, t0_oe;
  logic test_input_one, timer_overflow_flag, ext_irq_n, ext_irq_seen, pc_bank_bit;
  logic [31:0] paddr, pwdata, prdata, rd;
  logic [7:0] prog_data, xd_rdata, rnd;
  logic [15:0] seed;
  mbc_pkg::mbc_pbus_t prog;
  mbc_pkg::mbc_xbus_t xbus;
  logic [32:0] exp_q [$];
  int n_mismatch, num_checks, n;
  // pin level follows the core while it drives
  wire logic test_input_zero = t0_oe ? t0_out : t0_drv;
  mbc_core i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .prog(prog), .prog_data(prog_data), .xbus(xbus),
    .xd_rdata(xd_rdata), .test_input_zero(test_input_zero), .t0_out(t0_out),
    .t0_oe(t0_oe), .test_input_one(test_input_one),
    .timer_overflow_flag(timer_overflow_flag), .ext_irq_n(ext_irq_n),
    .ext_irq_seen(ext_irq_seen), .pc_bank_bit(pc_bank_bit));
  mbc_mem_model i_mem (.pclk(pclk), .prog(prog), .prog_data(prog_data), .xbus(xbus),
    .xd_rdata(xd_rdata));
  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction : lfsr
  task automatic apb(input logic w, input logic [31:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    @(posedge pclk);
    while (pready !== 1'b1 && n < 50) begin
      n++;
      @(posedge pclk);
    end
    if (n >= 50) begin
      n_mismatch++;
    end
    rd = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic rd_chk(input logic [31:0] a, input logic [32:0] e);
    exp_q.push_back(e);
    apb(1'b0, a, 32'h0);
  endtask : rd_chk
  task automatic end_of_test;
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : end_of_test
  // ****************************************
  // Read monitor
  // ****************************************
  always @(posedge pclk) begin
    if (psel && penable && pready === 1'b1 && !pwrite && exp_q.size() > 0) begin
      `CHK("apb read", exp_q.pop_front(), {pslverr, prdata})
    end
  end
  initial begin
    pclk = 1'b0;
    forever #4 pclk = ~pclk;
  end
  initial begin
    repeat (20000) @(posedge pclk);
    n_mismatch++;
    end_of_test();
  end
  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    logic [7:0] img [0:43];
    {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
    {t0_drv, test_input_one, timer_overflow_flag, ext_irq_n} = 4'b0110;
    seed = 16'd29943;
    repeat (5) seed = lfsr(seed);
    rnd = seed[7:0];
    img = '{8'h23, 8'h00, 8'hC6, 8'h06, 8'h23, 8'hFF, 8'h96, 8'h04, 8'hB8, 8'h5A, 8'h23,
      rnd, 8'h90, 8'h23, 8'h00, 8'h80, 8'h26, 8'h14, 8'h23, 8'hFF, 8'h46, 8'h12, 8'h56,
      8'h1A, 8'h23, 8'hFF, 8'h16, 8'h1E, 8'h23, 8'hFF, 8'h36, 8'h12, 8'hA7, 8'h95, 8'hB5,
      8'hA5, 8'hD5, 8'hF5, 8'h05, 8'h75, 8'h23, 8'h05, 8'hE3, 8'h96};
    for (int i = 0; i < 44; i++) begin
      i_mem.pmem[i] = img[i];
    end
    i_mem.pmem[44] = 8'h2B;
    i_mem.pmem[12'h305] = 8'hC3;
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    rd_chk(32'h0C, {1'b0, 24'h0, `MBC_PSW_RESET});
    apb(1'b1, 32'h00, 32'h1);
    n = 0;
    while (prog.addr !== 12'h02B && n < 2000) begin
      n++;
      @(posedge pclk);
    end
    if (n >= 2000) begin
      n_mismatch++;
    end
    apb(1'b1, 32'h00, 32'h0);
    repeat (10) @(posedge pclk);
    $display("test program done");
    `CHK("ext byte", rnd, i_mem.xmem[8'h5A])
    rd_chk(32'h08, {1'b0, 24'h0, 8'hC3});
    rd_chk(32'h0C, {1'b0, 24'h0, 8'hB8});
    rd_chk(32'h04, {1'b0, 32'h0F});
    rd_chk(32'h40, {1'b1, 32'h0});
    `CHK("irq seen", 1'b1, ext_irq_seen)
    `CHK("t0 drive", 1'b1, t0_oe)
    // counter stays in the low bank
    `CHK("pc bank", 1'b0, pc_bank_bit)
    repeat (3) @(posedge pclk);
    `CHK("queue empty", 0, exp_q.size())
    $display("test registers done");
    end_of_test();
  end
endmodule : testbench
